// *** core/wdslp_defs.svh ***
`ifndef WDSLP_DEFS_SVH
`define WDSLP_DEFS_SVH
// register byte addresses on the bus
`define WDSLP_ADDR_WDCTRL    8'h00
`define WDSLP_ADDR_OPTCTRL   8'h04
`define WDSLP_ADDR_CFGWORD   8'h08
`define WDSLP_ADDR_STATUS    8'h0c
`define WDSLP_ADDR_CORECMD   8'h10
// reset values and write mask
`define WDSLP_WDCTRL_RST     8'h08
`define WDSLP_OPTCTRL_RST    8'hff
`define WDSLP_WDCTRL_MASK    8'h1f
// field positions
`define WDSLP_SOFTON_BIT     0
`define WDSLP_PSEL_LO        1
`define WDSLP_PSEL_HI        4
`define WDSLP_CFG_WDON_BIT   3
`define WDSLP_CFG_WAKERST    7
`define WDSLP_CMD_KICK       0
`define WDSLP_CMD_SLEEP      1
`define WDSLP_CMD_OSCFAIL    2
// prescaler select
`define WDSLP_PSEL_MAX       4'hb
`define WDSLP_PSEL_BASE      5
// time base, timing and interrupt vector
`define WDSLP_SLOWOSC_KHZ    31
`define WDSLP_CLK_KHZ        40000
`define WDSLP_INT_VECTOR     13'h0004
`endif

// *** core/wdslp_pkg.sv ***
package wdslp_pkg;
	typedef enum logic [1:0] {WDSLP_AWAKE, WDSLP_ASLEEP, WDSLP_STARTUP} wdslp_mode_t;

	typedef struct packed {
		logic [7:0]  wdCtrl;
		logic [7:0]  optCtrl;
		logic [7:0]  cfgWord;
		logic        cfgValid;
		wdslp_mode_t mode;
		logic        asleep;
		logic [15:0] osCnt;
		logic [15:0] preCnt;
		logic [7:0]  wdCnt;
		logic [15:0] startCnt;
		logic        expiredN;
		logic        powerdownN;
		logic        devReset;
		logic        vectorJump;
		logic        oscStop;
		logic        pinHold;
		logic        aWrite;
		logic        aRead;
		logic [7:0]  aAddr;
		logic        hreadyOut;
		logic [31:0] hrdata;
	} wdslp_state_t;
endpackage : wdslp_pkg

// *** core/wdslp_top.sv ***
`timescale 1ns/1ps
`include "wdslp_defs.svh"
// How it works
// - watchdog counts a slow tick made by dividing the system clock by OSC_DIV (about 31 kHz by default).
// - any reset loads watchdog_control with 0x08: 1:512 ratio, software enable off.
// - watchdog held in reset while the crystal start-up count runs.
// - 16-bit prescaler divides the slow clock by 32 up to 65536.
// - with cfg_watchdog_on set the watchdog always runs.
// - with cfg_watchdog_on clear, soft_watchdog_on turns the watchdog on and off.
// - kick, oscillator failure and sleep exit clear the count; watchdog off (config and soft enable both clear) holds it cleared.
// - after crystal-clock wake the watchdog stays cleared until start-up delay ends.
// - period select bits 4-1 pick 1:32..1:65536; codes 1100-1111 reserved.
// - sleep clears watchdog, clears powerdown, sets expired flag, stops oscillator, holds pins.
// - external reset pin wake resets; watchdog or interrupt wake continues execution.
// - watchdog wake clears expired flag; powerdown set on power-up, cleared on sleep.
// - enabled interrupt wakes device regardless of global_irq_enable.
// - after interrupt wake, next instruction runs then vector jump if global enable.
// - every wake-up clears the watchdog counter.
// - sleep with interrupt already pending acts as no-op, nothing cleared or changed.
// - interrupt during sleep completes sleep effects then wakes at once.
// - only clockless sources may wake the device.
// - watchdog reset is internal only, never drives the external reset pin.
// - wake_reset_cfg zero makes every wake-up a full device reset.
module wdslp_top #(
	parameter int WDCNT_W      = 8,
	parameter int STARTUP_CYC  = 1024,
	parameter int OSC_DIV      = (`WDSLP_CLK_KHZ + `WDSLP_SLOWOSC_KHZ - 1) / `WDSLP_SLOWOSC_KHZ
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	input  wire logic [7:0]  cfgWordIn,
	input  wire logic        crystalClock,
	input  wire logic        externalResetPin,
	input  wire logic        globalIrqEnable,
	input  wire logic [4:0]  wakeIrqPending,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             deviceReset,
	output logic             vectorJump,
	output logic             oscDriverOff,
	output logic             pinStateHold,
	output logic             sleeping,
	output logic             externalResetPinDrive
);
	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// prescale ratio select: code 0 divides by 32, each code doubles, reserved codes clamp
	function automatic logic [15:0] ratioMask(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > `WDSLP_PSEL_MAX) ? `WDSLP_PSEL_MAX : sel;
		ratioMask = 16'((32'h1 << (32'(s) + `WDSLP_PSEL_BASE)) - 32'h1);
	endfunction : ratioMask

	// address decode shared by the write strobes and the read mux
	function automatic logic regHit(input logic [7:0] addr, input logic [7:0] target);
		regHit = addr == target;
	endfunction : regHit

	// status word: start-up, asleep, expired (low = timed out), powerdown (low = slept), count
	function automatic logic [31:0] statusWord(input wdslp_pkg::wdslp_state_t st);
		statusWord = {20'h0, st.mode == wdslp_pkg::WDSLP_STARTUP,
			st.mode == wdslp_pkg::WDSLP_ASLEEP, st.expiredN, st.powerdownN, st.wdCnt};
	endfunction : statusWord

	// read mux: unmapped and write-only offsets return zero
	function automatic logic [31:0] readMux(input logic [7:0] addr,
		input wdslp_pkg::wdslp_state_t st);
		logic [31:0] d;
		d = 32'h0;
		if (regHit(addr, `WDSLP_ADDR_WDCTRL))
			d = {24'h0, st.wdCtrl};
		if (regHit(addr, `WDSLP_ADDR_OPTCTRL))
			d = {24'h0, st.optCtrl};
		if (regHit(addr, `WDSLP_ADDR_CFGWORD))
			d = {24'h0, st.cfgWord};
		if (regHit(addr, `WDSLP_ADDR_STATUS))
			d = statusWord(st);
		readMux = d;
	endfunction : readMux

	wdslp_pkg::wdslp_state_t s, n;

	logic wdOn;
	logic kick;
	logic sleepCmd;
	logic oscFail;
	logic irqWake;
	logic osTick;
	logic preTick;
	logic wdOvf;
	logic wakeRstCfgN;
	logic wrHit;

	////////////////////////////////////////////////////////////////////////////////
	// decode

	always_comb
	begin
		wrHit       = s.aWrite && regHit(s.aAddr, `WDSLP_ADDR_CORECMD);
		kick        = wrHit && hwdata[`WDSLP_CMD_KICK];
		sleepCmd    = wrHit && hwdata[`WDSLP_CMD_SLEEP];
		oscFail     = wrHit && hwdata[`WDSLP_CMD_OSCFAIL];
		irqWake     = |wakeIrqPending;
		wdOn        = s.cfgWord[`WDSLP_CFG_WDON_BIT] || s.wdCtrl[`WDSLP_SOFTON_BIT];
		wakeRstCfgN = s.cfgWord[`WDSLP_CFG_WAKERST];
		osTick      = s.osCnt == 16'(OSC_DIV - 1);
		preTick     = osTick && ((s.preCnt & ratioMask(s.wdCtrl[`WDSLP_PSEL_HI:`WDSLP_PSEL_LO]))
			== ratioMask(s.wdCtrl[`WDSLP_PSEL_HI:`WDSLP_PSEL_LO]));
		wdOvf       = wdOn && s.mode != wdslp_pkg::WDSLP_STARTUP && preTick && (&s.wdCnt);
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		n = s;
		n.devReset   = 1'b0;
		n.vectorJump = 1'b0;
		if (!s.cfgValid)
		begin
			n.cfgWord  = cfgWordIn;
			n.cfgValid = 1'b1;
		end
		n.osCnt = osTick ? 16'h0 : s.osCnt + 16'h1;
		if (osTick)
			n.preCnt = s.preCnt + 16'h1;
		if (preTick)
			n.wdCnt = s.wdCnt + 8'h1;
		if (!wdOn || s.mode == wdslp_pkg::WDSLP_STARTUP)
		begin
			n.preCnt = 16'h0;
			n.wdCnt  = 8'h0;
		end
		if (kick || oscFail)
		begin
			n.preCnt = 16'h0;
			n.wdCnt  = 8'h0;
		end
		if (s.mode == wdslp_pkg::WDSLP_STARTUP)
		begin
			n.startCnt = s.startCnt + 16'h1;
			if (s.startCnt == 16'(STARTUP_CYC - 1))
			begin
				n.mode    = wdslp_pkg::WDSLP_AWAKE;
				n.pinHold = 1'b0;
			end
		end
		unique case (s.mode)
			wdslp_pkg::WDSLP_AWAKE:
			begin
				if (wdOvf)
				begin
					n.devReset = 1'b1;
					n.expiredN = 1'b0;
					n.wdCnt    = 8'h0;
					n.preCnt   = 16'h0;
				end
				else if (sleepCmd && !irqWake)
				begin
					n.mode       = wdslp_pkg::WDSLP_ASLEEP;
					n.preCnt     = 16'h0;
					n.wdCnt      = 8'h0;
					n.powerdownN = 1'b0;
					n.expiredN   = 1'b1;
					n.oscStop    = 1'b1;
					n.pinHold    = 1'b1;
				end
			end
			wdslp_pkg::WDSLP_ASLEEP:
			begin
				if (!externalResetPin || wdOvf || irqWake)
				begin
					n.preCnt   = 16'h0;
					n.wdCnt    = 8'h0;
					n.oscStop  = 1'b0;
					n.startCnt = 16'h0;
					n.mode     = crystalClock ? wdslp_pkg::WDSLP_STARTUP
						: wdslp_pkg::WDSLP_AWAKE;
					n.pinHold  = crystalClock;
					if (wdOvf)
						n.expiredN = 1'b0;
					if (!externalResetPin || !wakeRstCfgN)
						n.devReset = 1'b1;
					else if (irqWake && globalIrqEnable)
						n.vectorJump = 1'b1;
				end
			end
			wdslp_pkg::WDSLP_STARTUP:
			begin
			end
		endcase
		if (s.aWrite && regHit(s.aAddr, `WDSLP_ADDR_WDCTRL))
			n.wdCtrl = hwdata[7:0] & `WDSLP_WDCTRL_MASK;
		if (s.aWrite && regHit(s.aAddr, `WDSLP_ADDR_OPTCTRL))
			n.optCtrl = hwdata[7:0];
		if (n.devReset)
		begin
			n.wdCtrl  = `WDSLP_WDCTRL_RST;
			n.optCtrl = `WDSLP_OPTCTRL_RST;
		end
		// ahb-lite slave: zero wait states, reads answered in the data phase
		n.aWrite    = hsel && hready && htrans[1] && hwrite;
		n.aRead     = hsel && hready && htrans[1] && !hwrite;
		n.aAddr     = haddr[7:0];
		n.hreadyOut = 1'b1;
		n.asleep    = n.mode == wdslp_pkg::WDSLP_ASLEEP;
		n.hrdata    = 32'h0;
		// read the next state so a read issued in a write's data phase sees that write
		if (hsel && hready && htrans[1] && !hwrite)
			n.hrdata = readMux(haddr[7:0], n);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			s            <= '0;
			s.wdCtrl     <= `WDSLP_WDCTRL_RST;
			s.optCtrl    <= `WDSLP_OPTCTRL_RST;
			s.mode       <= wdslp_pkg::WDSLP_AWAKE;
			s.expiredN   <= 1'b1;
			s.powerdownN <= 1'b1;
			s.hreadyOut  <= 1'b1;
		end
		else if (clkEn)
			s <= n;
	end

	assign hrdata                = s.hrdata;
	assign hreadyout             = s.hreadyOut;
	assign hresp                 = 1'b0;
	assign deviceReset           = s.devReset;
	assign vectorJump            = s.vectorJump;
	assign oscDriverOff          = s.oscStop;
	assign pinStateHold          = s.pinHold;
	assign sleeping              = s.asleep;
	assign externalResetPinDrive = 1'b0;
endmodule : wdslp_top

// *** testbench/wdslp_checker.sv ***
`timescale 1ns/1ps
module wdslp_checker (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [7:0] cfgWordIn,
	input wire logic       externalResetPin,
	input wire logic       globalIrqEnable,
	input wire logic [4:0] wakeIrqPending,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       deviceReset,
	input wire logic       vectorJump,
	input wire logic       oscDriverOff,
	input wire logic       pinStateHold,
	input wire logic       sleeping,
	input wire logic       externalResetPinDrive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence pinWake;
		sleeping && !externalResetPin;
	endsequence
	sequence irqWake;
		sleeping && (wakeIrqPending != 5'h00);
	endsequence
	chk_sleep_effects: assert property ($rose(sleeping) |-> oscDriverOff && pinStateHold)
		else $error("sleep entry without osc stop or pin hold");
	chk_pin_reset: assert property (pinWake |-> ##[0:3] deviceReset)
		else $error("reset pin wake gave no device reset");
	chk_irq_wake: assert property (irqWake |-> ##[1:4] !sleeping)
		else $error("enabled interrupt did not wake");
	chk_vector_gie: assert property (vectorJump |-> $past(globalIrqEnable) && !deviceReset)
		else $error("vector jump without global enable");
	chk_jump_on_wake: assert property (vectorJump |-> $fell(sleeping))
		else $error("vector jump outside a wake-up");
	chk_no_pin_drive: assert property (externalResetPinDrive == 1'b0)
		else $error("reset pin driven");
	chk_wake_reset: assert property (!cfgWordIn[7] && $fell(sleeping) |-> ##[0:2] deviceReset)
		else $error("wake without forced reset");
	chk_pulse_short: assert property (deviceReset |=> !deviceReset)
		else $error("device reset longer than one cycle");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
endmodule : wdslp_checker

// *** testbench/test_watchdog_sleep_wakeup.sv ***
`timescale 1ns/1ps
`include "wdslp_defs.svh"
module test_watchdog_sleep_wakeup;
	logic        clk, nrst, clkEn, crystalClock, externalResetPin, globalIrqEnable;
	logic [7:0]  cfgWordIn;
	logic [4:0]  wakeIrqPending;
	logic        hsel, hwrite, hreadyout, hresp, deviceReset, vectorJump;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        oscDriverOff, pinStateHold, sleeping, externalResetPinDrive;
	logic [7:0]  cnt;
	int          nFail, checks;
	wdslp_top #(.OSC_DIV(1), .STARTUP_CYC(8)) dut (.clk(clk), .nrst(nrst), .clkEn(clkEn),
		.cfgWordIn(cfgWordIn), .crystalClock(crystalClock), .externalResetPin(externalResetPin),
		.globalIrqEnable(globalIrqEnable), .wakeIrqPending(wakeIrqPending), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.deviceReset(deviceReset), .vectorJump(vectorJump), .oscDriverOff(oscDriverOff),
		.pinStateHold(pinStateHold), .sleeping(sleeping),
		.externalResetPinDrive(externalResetPinDrive));
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			nFail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		n = 0;
		haddr <= {24'h00, a};
		hwrite <= w;
		htrans <= 2'b10;
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'b00;
		hwdata <= wd;
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		v = hrdata;
		if (n >= 50)
		begin
			nFail++;
			tally_and_finish();
		end
	endtask : xfer
	task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		check(nm, v & m, e);
	endtask : rdChk
	task automatic waitSig(input int which);
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (n < 20000 && !(which == 0 ?
			vectorJump === 1'b1 : which == 1 ? sleeping === 1'b0 : deviceReset === 1'b1));
		check("wait", n < 20000, 1);
		if (n >= 20000)
			tally_and_finish();
	endtask : waitSig
	initial
	begin
		{nrst, hsel, hwrite, globalIrqEnable, crystalClock} = 0;
		{clkEn, externalResetPin} = 2'b11;
		cfgWordIn = 8'h80;
		wakeIrqPending = 5'h00;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		hsel <= 1'b1;
		rdChk("wdctrl", `WDSLP_ADDR_WDCTRL, 32'hff, 32'h08);
		rdChk("optctrl", `WDSLP_ADDR_OPTCTRL, 32'hff, 32'hff);
		rdChk("flags", `WDSLP_ADDR_STATUS, 32'h700, 32'h300);
		rdChk("unmapped", 8'h40, 32'hffffffff, 32'h0);
		xfer(`WDSLP_ADDR_WDCTRL, 1'b1, 32'hff);
		rdChk("wdctrl", `WDSLP_ADDR_WDCTRL, 32'hff, 32'h1f);
		xfer(`WDSLP_ADDR_WDCTRL, 1'b1, 32'h01);
		repeat (200) @(posedge clk);
		xfer(`WDSLP_ADDR_STATUS, 1'b0, 32'h0);
		check("running", v[7:0] > 8'h01, 1);
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h01);
		rdChk("kicked", `WDSLP_ADDR_STATUS, 32'hfe, 32'h0);
		wakeIrqPending <= 5'h01;
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h02);
		rdChk("noop sleep", `WDSLP_ADDR_STATUS, 32'h7fe, 32'h300);
		wakeIrqPending <= 5'h00;
		globalIrqEnable <= 1'b1;
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h02);
		rdChk("asleep", `WDSLP_ADDR_STATUS, 32'h7fe, 32'h600);
		wakeIrqPending <= 5'h10;
		waitSig(0);
		wakeIrqPending <= 5'h00;
		rdChk("irq wake", `WDSLP_ADDR_STATUS, 32'h7fe, 32'h200);
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h02);
		waitSig(1);
		rdChk("wd wake", `WDSLP_ADDR_STATUS, 32'h700, 32'h0);
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h02);
		externalResetPin <= 1'b0;
		waitSig(2);
		externalResetPin <= 1'b1;
		rdChk("pin reset", `WDSLP_ADDR_WDCTRL, 32'hff, 32'h08);
		xfer(`WDSLP_ADDR_WDCTRL, 1'b1, 32'h01);
		repeat (40) @(posedge clk);
		xfer(`WDSLP_ADDR_STATUS, 1'b0, 32'h0);
		cnt = v[7:0];
		clkEn <= 1'b0;
		repeat (100) @(posedge clk);
		clkEn <= 1'b1;
		xfer(`WDSLP_ADDR_STATUS, 1'b0, 32'h0);
		check("frozen", (v[7:0] - cnt) <= 8'h01, 1);
		nrst <= 1'b0;
		cfgWordIn <= 8'h08;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rdChk("cfg word", `WDSLP_ADDR_CFGWORD, 32'hff, 32'h08);
		xfer(`WDSLP_ADDR_WDCTRL, 1'b1, 32'h00);
		repeat (200) @(posedge clk);
		xfer(`WDSLP_ADDR_STATUS, 1'b0, 32'h0);
		check("config on", v[7:0] > 8'h01, 1);
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h04);
		rdChk("osc fail", `WDSLP_ADDR_STATUS, 32'hfe, 32'h0);
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h01);
		xfer(`WDSLP_ADDR_CORECMD, 1'b1, 32'h02);
		crystalClock <= 1'b1;
		wakeIrqPending <= 5'h04;
		waitSig(2);
		wakeIrqPending <= 5'h00;
		rdChk("start-up", `WDSLP_ADDR_STATUS, 32'hfff, 32'ha00);
		crystalClock <= 1'b0;
		xfer(`WDSLP_ADDR_WDCTRL, 1'b1, 32'h00);
		repeat (8) @(posedge clk);
		rdChk("awake", `WDSLP_ADDR_STATUS, 32'hf00, 32'h200);
		waitSig(2);
		rdChk("expired", `WDSLP_ADDR_STATUS, 32'h700, 32'h0);
		tally_and_finish();
	end
endmodule : test_watchdog_sleep_wakeup
bind wdslp_top wdslp_checker chk (.clk(clk), .nrst(nrst), .cfgWordIn(cfgWordIn),
	.externalResetPin(externalResetPin), .globalIrqEnable(globalIrqEnable),
	.wakeIrqPending(wakeIrqPending), .hreadyout(hreadyout), .hresp(hresp),
	.deviceReset(deviceReset), .vectorJump(vectorJump), .oscDriverOff(oscDriverOff),
	.pinStateHold(pinStateHold), .sleeping(sleeping),
	.externalResetPinDrive(externalResetPinDrive));
